// >>> logic/vector_select_permute_unit.sv
// select, arrange, pack and splat datapath for 64-bit vector registers
//
// Functional notes
// RULE1 - word select by chosen condition field
// RULE2 - bit select by destination vector
// RULE3 - insert second source where mask zero
// RULE4 - insert second source where mask one
// RULE5 - byte de-interleave, four even/odd combinations
// RULE6 - halfword de-interleave, even/odd combinations
// RULE7 - halfword interleave with even/odd/high/low picks
// RULE8 - merge high or low words
// RULE9 - permute second source by first source
// RULE10 - permute both sources by destination control
// RULE11 - permute destination and second by first
// RULE12 - doubleword pack, saturate, fractional rounds
// RULE13 - guarded 33.31/17.47 pack with rounding
// RULE14 - halfword to byte pack with saturation
// RULE15 - word to halfword pack, interleave, fractional
// RULE16 - replicate chosen byte or halfword
// RULE17 - fractional immediate splat, optional accumulator
// RULE18 - integer immediate splat, optional accumulator
// RULE19 - halfword swap variants
// RULE20 - byte-pair swap variants
// RULE21 - unpack bytes and halfwords, widened
// RULE22 - unpack word to 17.47 guarded
// RULE23 - 64-bit registers, element 0 most significant
// RULE24 - extract zeroes rest, insert keeps rest
`timescale 1ns/1ps
module vector_select_permute_unit import vsp_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // issue from decode
   input wire logic issue_valid,
   input wire request_t req,
   // condition and rounding state
   input wire logic [31:0] cond_reg,
   input wire rnd_mode_t rnd_mode,
   // result to register file and accumulator
   output logic res_valid,
   output result_t res
);

   // ******
   // operands
   // ******

   wire logic [63:0] a = req.first_source_reg;
   wire logic [63:0] b = req.second_source_reg;
   wire logic [63:0] d = req.dest_reg;
   wire logic [3:0] v = req.vrnt;
   wire logic [2:0] si = req.isrc;
   wire logic [2:0] di = req.idst;

   // byte of the 16-byte pair, byte 0 highest
   function automatic logic [7:0] byte16(input logic [63:0] hi, input logic [63:0] lo,
                                         input logic [3:0] idx);
      logic [127:0] cat;
      cat = {hi, lo};
      byte16 = cat[8*(15-idx) +: 8];
   endfunction : byte16

   function automatic logic [15:0] ilv_pick(input logic [63:0] src, input logic [1:0] pick,
                                            input logic k);
      logic [1:0] idx;
      case (pick)
         PICK_EVEN: idx = {k, 1'b0};
         PICK_ODD: idx = {k, 1'b1};
         PICK_HIGH: idx = {1'b0, k};
         default: idx = {1'b1, k};
      endcase
      ilv_pick = half_of(src, idx);
   endfunction : ilv_pick

   // ******
   // select forms
   // ******

   // condition register bit 0 is its most significant bit
   wire logic [4:0] cr_sh = 5'd28 - {req.condition_field_select, 2'b00};
   wire logic [31:0] cr_shifted = cond_reg >> cr_sh;
   wire logic [3:0] cr_field = cr_shifted[3:0];
   wire logic c_hi = cr_field[3];
   wire logic c_lo = cr_field[2];

   wire logic [63:0] sel_res;
   assign sel_res[63:32] = c_hi ? a[63:32] : b[63:32]; // [RULE1]
   assign sel_res[31:0] = c_lo ? a[31:0] : b[31:0]; // [RULE1]

   wire logic [63:0] selbit_res = (d & a) | (~d & b); // [RULE2]
   wire logic [63:0] m0_res = (~a & b) | (a & d); // [RULE3]
   wire logic [63:0] m1_res = (a & b) | (~a & d); // [RULE4]

   // ******
   // de-interleave, interleave, merge
   // ******

   wire logic ao = v[A_ODD_BIT];
   wire logic bo = v[B_ODD_BIT];

   wire logic [63:0] dlvb_res;
   for (genvar i = 0; i < 4; i++) begin : g_dlv
      localparam logic [2:0] E = 3'(2 * i);
      assign dlvb_res[8*(7-i) +: 8] = byte_of(a, E | {2'b00, ao}); // [RULE5]
      assign dlvb_res[8*(3-i) +: 8] = byte_of(b, E | {2'b00, bo}); // [RULE5]
   end

   wire logic [63:0] dlvh_res;
   assign dlvh_res[63:48] = half_of(a, {1'b0, ao}); // [RULE6]
   assign dlvh_res[47:32] = half_of(a, {1'b1, ao}); // [RULE6]
   assign dlvh_res[31:16] = half_of(b, {1'b0, bo}); // [RULE6]
   assign dlvh_res[15:0] = half_of(b, {1'b1, bo}); // [RULE6]

   // first source feeds even slots, second source odd slots
   wire logic [63:0] ilv_res;
   assign ilv_res[63:48] = ilv_pick(a, v[3:2], 1'b0); // [RULE7]
   assign ilv_res[47:32] = ilv_pick(b, v[1:0], 1'b0); // [RULE7]
   assign ilv_res[31:16] = ilv_pick(a, v[3:2], 1'b1); // [RULE7]
   assign ilv_res[15:0] = ilv_pick(b, v[1:0], 1'b1); // [RULE7]

   wire logic [63:0] merge_res;
   assign merge_res[63:32] = v[A_LOW_BIT] ? a[31:0] : a[63:32]; // [RULE8]
   assign merge_res[31:0] = v[B_LOW_BIT] ? b[31:0] : b[63:32]; // [RULE8]

   // ******
   // permutes, byte extract and insert
   // ******

   wire logic [63:0] perm_res;
   wire logic [63:0] perm2_res;
   wire logic [63:0] perm3_res;
   wire logic [63:0] xtrb_res;
   wire logic [63:0] xtrd_res;
   wire logic [63:0] insb_res;

   for (genvar i = 0; i < 8; i++) begin : g_byte
      localparam logic [2:0] IDX = 3'(i);
      wire logic [7:0] ca = byte_of(a, IDX);
      wire logic [7:0] cd = byte_of(d, IDX);
      // only the low control bits take part; upper bits are ignored
      assign perm_res[8*(7-i) +: 8] = byte_of(b, ca[2:0]); // [RULE9]
      assign perm2_res[8*(7-i) +: 8] = byte16(a, b, cd[3:0]); // [RULE10]
      assign perm3_res[8*(7-i) +: 8] = byte16(d, b, ca[3:0]); // [RULE11]
      assign xtrb_res[8*(7-i) +: 8] = (di == IDX) ? byte_of(a, si) : 8'h00; // [RULE24]
      assign xtrd_res[8*(7-i) +: 8] = byte16(a, b, {1'b0, si} + {1'b0, IDX}); // [RULE24]
      assign insb_res[8*(7-i) +: 8] = (di == IDX) ? byte_of(a, si) : cd; // [RULE24]
   end

   // ******
   // halfword extract and insert
   // ******

   wire logic [63:0] xtrh_res;
   wire logic [63:0] insh_res;

   for (genvar k = 0; k < 4; k++) begin : g_half
      localparam logic [1:0] HIDX = 2'(k);
      wire logic hit = (di[1:0] == HIDX);
      wire logic [15:0] pick = half_of(a, si[1:0]);
      assign xtrh_res[16*(3-k) +: 16] = hit ? pick : 16'h0000; // [RULE24]
      assign insh_res[16*(3-k) +: 16] = hit ? pick : half_of(d, HIDX); // [RULE24]
   end

   // ******
   // element replicate
   // ******

   wire logic [63:0] splat_e_res;
   assign splat_e_res = v[HALF_BIT] ? {4{half_of(a, si[1:0])}} : {8{byte_of(a, si)}}; // [RULE16]

   // ******
   // immediate replicate
   // ******

   wire logic [63:0] splat_i_res;
   wire logic splat_frac = (req.op == OP_SPLAT_FI);
   wire logic splat_op = splat_frac || (req.op == OP_SPLAT_I);

   imm_splat_unit u_splat (
      .frac(splat_frac),
      .size(v[1:0]),
      .partial(v[PARTIAL_BIT]),
      .imm(req.signed_small_immediate),
      .splat_res(splat_i_res)
   );

   // accumulating forms copy the same value into the accumulator
   wire logic acc_we_d = issue_valid && splat_op && v[ACC_BIT]; // [RULE17] [RULE18]

   // ******
   // pack
   // ******

   wire logic [63:0] pack_res;

   pack_saturate_unit u_pack (
      .op(req.op),
      .vrnt(v),
      .rnd_mode(rnd_mode),
      .a(a),
      .b(b),
      .pack_res(pack_res)
   );

   // ******
   // swap
   // ******

   wire logic [15:0] ah0 = half_of(a, 2'd0);
   wire logic [15:0] ah1 = half_of(a, 2'd1);
   wire logic [15:0] ah2 = half_of(a, 2'd2);
   wire logic [15:0] ah3 = half_of(a, 2'd3);
   wire logic [15:0] bh0 = half_of(b, 2'd0);
   wire logic [15:0] bh1 = half_of(b, 2'd1);
   wire logic [15:0] bh2 = half_of(b, 2'd2);
   wire logic [15:0] bh3 = half_of(b, 2'd3);

   // bytes swapped within each pair
   wire logic [63:0] a_bsw = {a[55:48], a[63:56], a[39:32], a[47:40],
                              a[23:16], a[31:24], a[7:0], a[15:8]};
   wire logic [63:0] b_bsw = {b[55:48], b[63:56], b[39:32], b[47:40],
                              b[23:16], b[31:24], b[7:0], b[15:8]};

   logic [63:0] swap_res;
   always_comb begin
      case (v)
         SW_HE: swap_res = {ah2, bh1, ah0, bh3}; // [RULE19]
         SW_HO: swap_res = {bh0, ah3, bh2, ah1}; // [RULE19]
         SW_HHI: swap_res = {ah1, ah0, bh2, bh3}; // [RULE19]
         SW_HHILO: swap_res = {ah1, ah0, bh3, bh2}; // [RULE19]
         SW_HLO: swap_res = {bh0, bh1, ah3, ah2}; // [RULE19]
         SW_HLOHI: swap_res = {ah3, ah2, bh1, bh0}; // [RULE19]
         SW_BHILO: swap_res = {a_bsw[63:32], b_bsw[31:0]}; // [RULE20]
         default: swap_res = {a_bsw[31:0], b_bsw[63:32]}; // [RULE20]
      endcase
   end

   // ******
   // unpack
   // ******

   wire logic [63:0] unpkb_res;
   wire logic ub_lo = v[LOW_B_BIT];
   wire logic ub_u = v[UNS_BIT];
   for (genvar i = 0; i < 4; i++) begin : g_unpkb
      wire logic [7:0] s = byte_of(a, {ub_lo, 2'(i)});
      assign unpkb_res[16*(3-i) +: 16] = {{8{s[7] & ~ub_u}}, s}; // [RULE21]
   end

   wire logic [63:0] unpkh_res;
   wire logic uh_lo = v[LOW_H_BIT];
   for (genvar k = 0; k < 2; k++) begin : g_unpkh
      wire logic [15:0] s = half_of(a, {uh_lo, 1'(k)});
      assign unpkh_res[32*(1-k) +: 32] =
         (v[1:0] == UW_FRAC) ? {s, 16'h0000} :
         (v[1:0] == UW_SINT) ? {{16{s[15]}}, s} : {16'h0000, s}; // [RULE21]
   end

   // 1.31 word moved under 16 guard bits and 16 extra fraction bits
   wire logic [31:0] wg_src = v[0] ? a[31:0] : a[63:32];
   wire logic [63:0] unpkwg_res = {{16{wg_src[31]}}, wg_src, 16'h0000}; // [RULE22]

   // ******
   // result select
   // ******

   logic [63:0] dest_d;
   always_comb begin
      case (req.op)
         OP_SEL: dest_d = sel_res;
         OP_SELBIT: dest_d = selbit_res;
         MASK_ZERO_INSERT_OP: dest_d = m0_res;
         MASK_ONE_INSERT_OP: dest_d = m1_res;
         OP_DLV_B: dest_d = dlvb_res;
         OP_DLV_H: dest_d = dlvh_res;
         OP_ILV_H: dest_d = ilv_res;
         OP_MERGE: dest_d = merge_res;
         OP_PERM: dest_d = perm_res;
         DUAL_SOURCE_PERMUTE_OP: dest_d = perm2_res;
         DEST_SOURCE_PERMUTE_OP: dest_d = perm3_res;
         OP_PACK_D: dest_d = pack_res;
         OP_PACK_G: dest_d = pack_res;
         OP_PACK_HB: dest_d = pack_res;
         OP_PACK_WH: dest_d = pack_res;
         OP_SPLAT_E: dest_d = splat_e_res;
         OP_SPLAT_FI: dest_d = splat_i_res;
         OP_SPLAT_I: dest_d = splat_i_res;
         OP_SWAP: dest_d = swap_res;
         OP_UNPK_B: dest_d = unpkb_res;
         OP_UNPK_H: dest_d = unpkh_res;
         OP_UNPK_WG: dest_d = unpkwg_res;
         OP_XTR_B: dest_d = xtrb_res;
         OP_XTR_H: dest_d = xtrh_res;
         OP_XTR_D: dest_d = xtrd_res;
         OP_INS_B: dest_d = insb_res;
         OP_INS_H: dest_d = insh_res;
         // no-op leaves the destination as it was
         default: dest_d = d;
      endcase
   end

   // ******
   // result register
   // ******

   // one register stage; data holds between issues
   result_t res_d;
   result_t res_q;
   logic res_valid_q;

   always_comb begin
      res_d.dest_data = issue_valid ? dest_d : res_q.dest_data; // [RULE23]
      res_d.acc_we = acc_we_d;
      res_d.acc_data = acc_we_d ? splat_i_res : res_q.acc_data;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         res_valid_q <= 1'b0;
         res_q <= '0;
      end else begin
         res_valid_q <= issue_valid;
         res_q <= res_d;
      end
   end

   assign res_valid = res_valid_q;
   assign res = res_q;

endmodule : vector_select_permute_unit

// >>> logic/vsp_pkg.sv
// types, codes and helpers shared by the select/permute datapath
package vsp_pkg;

   typedef enum logic [4:0] {
      OP_NONE, OP_SEL, OP_SELBIT,
      MASK_ZERO_INSERT_OP, MASK_ONE_INSERT_OP,
      OP_DLV_B, OP_DLV_H, OP_ILV_H, OP_MERGE,
      OP_PERM, DUAL_SOURCE_PERMUTE_OP, DEST_SOURCE_PERMUTE_OP,
      OP_PACK_D, OP_PACK_G, OP_PACK_HB, OP_PACK_WH,
      OP_SPLAT_E, OP_SPLAT_FI, OP_SPLAT_I, OP_SWAP,
      OP_UNPK_B, OP_UNPK_H, OP_UNPK_WG,
      OP_XTR_B, OP_XTR_H, OP_XTR_D, OP_INS_B, OP_INS_H
   } op_t;

   typedef enum logic [1:0] {
      RND_NEAREST, RND_ZERO, RND_POS_INF, RND_NEG_INF
   } rnd_mode_t;

   // variant field bit positions
   localparam int A_ODD_BIT = 1;
   localparam int B_ODD_BIT = 0;
   localparam int A_LOW_BIT = 1;
   localparam int B_LOW_BIT = 0;
   localparam int UNS_BIT = 0;
   localparam int HALF_BIT = 0;
   localparam int LOW_B_BIT = 1;
   localparam int LOW_H_BIT = 2;
   localparam int PARTIAL_BIT = 2;
   localparam int ACC_BIT = 3;

   // interleave picks
   localparam logic [1:0] PICK_EVEN = 2'h0;
   localparam logic [1:0] PICK_ODD = 2'h1;
   localparam logic [1:0] PICK_HIGH = 2'h2;

   // pack codes
   localparam logic [3:0] PK_SS = 4'h0;
   localparam logic [3:0] PK_SU = 4'h1;
   localparam logic [3:0] PK_UU = 4'h2;
   localparam logic [3:0] PK_SS_ILV = 4'h3;
   localparam logic [3:0] PK_FR = 4'h4;
   localparam logic [3:0] PK_FR_ILV = 4'h5;
   localparam logic [3:0] PG_Q31_H = 4'h0;
   localparam logic [3:0] PG_Q47_W = 4'h2;

   // unpack word kinds
   localparam logic [1:0] UW_FRAC = 2'h0;
   localparam logic [1:0] UW_SINT = 2'h1;

   // swap codes
   localparam logic [3:0] SW_HE = 4'h0;
   localparam logic [3:0] SW_HO = 4'h1;
   localparam logic [3:0] SW_HHI = 4'h2;
   localparam logic [3:0] SW_HHILO = 4'h3;
   localparam logic [3:0] SW_HLO = 4'h4;
   localparam logic [3:0] SW_HLOHI = 4'h5;
   localparam logic [3:0] SW_BHILO = 4'h6;

   // splat sizes and element masks
   localparam logic [1:0] SZ_B = 2'h0;
   localparam logic [1:0] SZ_H = 2'h1;
   localparam logic [1:0] SZ_W = 2'h2;
   localparam logic [63:0] EVEN_B_MASK = 64'hff00ff00ff00ff00;
   localparam logic [63:0] EVEN_H_MASK = 64'hffff0000ffff0000;
   localparam logic [63:0] EVEN_W_MASK = 64'hffffffff00000000;

   localparam logic [63:0] RESET_VEC = 64'h0;

   typedef struct packed {
      op_t op;
      logic [3:0] vrnt;
      logic [2:0] isrc;
      logic [2:0] idst;
      logic [4:0] signed_small_immediate;
      logic [2:0] condition_field_select;
      logic [63:0] first_source_reg;
      logic [63:0] second_source_reg;
      logic [63:0] dest_reg;
   } request_t;

   typedef struct packed {
      logic [63:0] dest_data;
      logic acc_we;
      logic [63:0] acc_data;
   } result_t;

   // element 0 is the most significant
   function automatic logic [7:0] byte_of(input logic [63:0] v, input logic [2:0] i);
      byte_of = v[8*(7-i) +: 8];
   endfunction : byte_of

   function automatic logic [15:0] half_of(input logic [63:0] v, input logic [1:0] i);
      half_of = v[16*(3-i) +: 16];
   endfunction : half_of

endpackage : vsp_pkg

// >>> logic/pack_saturate_unit.sv
// saturating, rounding pack forms of the select/permute datapath
`timescale 1ns/1ps
module pack_saturate_unit import vsp_pkg::*; (
   // operation
   input wire op_t op,
   input wire logic [3:0] vrnt,
   input wire rnd_mode_t rnd_mode,
   // operands
   input wire logic [63:0] a,
   input wire logic [63:0] b,
   // narrowed value
   output logic [63:0] pack_res
);

   function automatic logic [31:0] narrow(input logic signed [65:0] x, input logic [5:0] sh,
                                          input rnd_mode_t rm, input logic [5:0] nb, input logic uns);
      logic signed [65:0] q;
      logic signed [65:0] rem;
      logic signed [65:0] half;
      logic signed [65:0] maxv;
      logic signed [65:0] minv;
      logic inc;
      q = x >>> sh;
      rem = x - (q <<< sh);
      half = (sh == 6'd0) ? 66'sd0 : (66'sd1 <<< (sh - 6'd1));
      case (rm)
         RND_NEAREST: inc = (sh != 6'd0) && ((rem > half) || ((rem == half) && q[0]));
         RND_ZERO: inc = (rem != 66'sd0) && x[65];
         RND_POS_INF: inc = (rem != 66'sd0);
         default: inc = 1'b0;
      endcase
      q = q + $signed({65'd0, inc});
      maxv = uns ? ((66'sd1 <<< nb) - 66'sd1) : ((66'sd1 <<< (nb - 6'd1)) - 66'sd1);
      minv = uns ? 66'sd0 : -(66'sd1 <<< (nb - 6'd1));
      if (q > maxv) begin
         q = maxv;
      end else if (q < minv) begin
         q = minv;
      end
      narrow = q[31:0];
   endfunction : narrow

   function automatic logic signed [65:0] ext(input logic [63:0] v, input logic uns);
      ext = uns ? {2'b00, v} : {{2{v[63]}}, v};
   endfunction : ext

   // doubleword and guarded forms
   wire logic pd_u = (vrnt == PK_UU);
   wire logic [5:0] pd_sh = (vrnt == PK_FR) ? 6'd32 : 6'd0;
   wire logic [31:0] pd_a = narrow(ext(a, pd_u), pd_sh, rnd_mode, 6'd32, pd_u);
   wire logic [31:0] pd_b = narrow(ext(b, pd_u), pd_sh, rnd_mode, 6'd32, pd_u);
   // 33.31 and 17.47 both keep a 1.15 or 1.31 result
   wire logic [5:0] pg_sh = (vrnt == PG_Q31_H || vrnt == PG_Q47_W) ? 6'd16 : 6'd32;
   wire logic [5:0] pg_nb = (vrnt == PG_Q47_W) ? 6'd32 : 6'd16;
   wire logic [31:0] pg_a = narrow(ext(a, 1'b0), pg_sh, rnd_mode, pg_nb, 1'b0);
   wire logic [31:0] pg_b = narrow(ext(b, 1'b0), pg_sh, rnd_mode, pg_nb, 1'b0);

   // halfword to byte and word to halfword
   wire logic hb_ou = (vrnt != PK_SS);
   wire logic wh_f = (vrnt == PK_FR) || (vrnt == PK_FR_ILV);
   wire logic wh_il = (vrnt == PK_SS_ILV) || (vrnt == PK_FR_ILV);
   wire logic wh_ou = (vrnt == PK_SU) || (vrnt == PK_UU);
   wire logic [63:0] hb_res;
   wire logic [63:0] wh_res;
   for (genvar i = 0; i < 8; i++) begin : g_hb
      wire logic [15:0] h = (i < 4) ? half_of(a, 2'(i)) : half_of(b, 2'(i - 4));
      wire logic [31:0] n = narrow(ext({{48{h[15] & ~pd_u}}, h}, 1'b0), 6'd0, rnd_mode, 6'd8, hb_ou);
      assign hb_res[8*(7-i) +: 8] = n[7:0];
   end
   for (genvar k = 0; k < 4; k++) begin : g_wh
      wire logic [31:0] w = (k < 2) ? a[32*(1-k%2) +: 32] : b[32*(1-k%2) +: 32];
      wire logic [31:0] n = narrow(ext({{32{w[31] & ~pd_u}}, w}, 1'b0), wh_f ? 6'd16 : 6'd0,
                                   rnd_mode, 6'd16, wh_ou);
   end
   // interleaved order puts first and second source halves alternately
   assign wh_res = wh_il ? {g_wh[0].n[15:0], g_wh[2].n[15:0], g_wh[1].n[15:0], g_wh[3].n[15:0]} :
                   {g_wh[0].n[15:0], g_wh[1].n[15:0], g_wh[2].n[15:0], g_wh[3].n[15:0]};

   always_comb begin
      case (op)
         OP_PACK_D: pack_res = {pd_a, pd_b}; // [RULE12]
         OP_PACK_G: pack_res = (vrnt == PG_Q47_W) ? {pg_a, pg_b} :
                               {pg_a[15:0], 16'h0000, pg_b[15:0], 16'h0000}; // [RULE13]
         OP_PACK_HB: pack_res = hb_res; // [RULE14]
         OP_PACK_WH: pack_res = wh_res; // [RULE15]
         default: pack_res = RESET_VEC;
      endcase
   end

endmodule : pack_saturate_unit

// >>> logic/imm_splat_unit.sv
// immediate replicate for the select/permute datapath
`timescale 1ns/1ps
module imm_splat_unit import vsp_pkg::*; (
   // form
   input wire logic frac,
   input wire logic [1:0] size,
   input wire logic partial,
   input wire logic [4:0] imm,
   // replicated value
   output logic [63:0] splat_res
);

   wire logic [6:0] es = 7'd8 << size;
   // fraction sits at the top of its element
   wire logic [63:0] ev = frac ? ({imm, 59'h0} >> (7'd64 - es)) : {{59{imm[4]}}, imm};
   wire logic [63:0] even_m = (size == SZ_B) ? EVEN_B_MASK :
                              (size == SZ_H) ? EVEN_H_MASK :
                              (size == SZ_W) ? EVEN_W_MASK : {64{1'b1}};
   // fractional partial form fills odd elements, integer form the even ones
   wire logic [63:0] keep = (!partial || &size) ? {64{1'b1}} : frac ? ~even_m : even_m;
   wire logic [63:0] full = (size == SZ_B) ? {8{ev[7:0]}} :
                            (size == SZ_H) ? {4{ev[15:0]}} :
                            (size == SZ_W) ? {2{ev[31:0]}} : ev;
   assign splat_res = full & keep; // [RULE17] [RULE18]

endmodule : imm_splat_unit

// >>> verification/vsp_unit_checker.sv
// port assertions for the select/permute datapath
`timescale 1ns/1ps
module vsp_unit_checker import vsp_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // issue
   input wire logic issue_valid,
   input wire request_t req,
   input wire logic [31:0] cond_reg,
   input wire rnd_mode_t rnd_mode,
   // result
   input wire logic res_valid,
   input wire result_t res
);
   request_t p_q;
   logic [31:0] c_q;
   wire logic [63:0] a = p_q.first_source_reg;
   wire logic [63:0] b = p_q.second_source_reg;
   wire logic [63:0] d = p_q.dest_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // copy of the taken request, read one edge later
   always_ff @(posedge sys_clk) begin
      p_q <= req;
      c_q <= cond_reg;
   end
   property yields(op_t o, logic [63:0] v);
      issue_valid && req.op == o |=> res_valid && res.dest_data == v;
   endproperty
   // ******
   // checks
   // ******
   wsel_hi_a: assert property (issue_valid && req.op == OP_SEL |=>
      res.dest_data[63:32] == (c_q[31-4*p_q.condition_field_select] ? a[63:32] : b[63:32])) else $error("word select");
   selbit_a: assert property (yields(OP_SELBIT, (d & a) | (~d & b))) else $error("bit select");
   mask_zero_a: assert property (yields(MASK_ZERO_INSERT_OP, (~a & b) | (a & d))) else $error("mask 0");
   mask_one_a: assert property (yields(MASK_ONE_INSERT_OP, (a & b) | (~a & d))) else $error("mask 1");
   merge_words_a: assert property (yields(OP_MERGE,
      {p_q.vrnt[1] ? a[31:0] : a[63:32], p_q.vrnt[0] ? b[31:0] : b[63:32]})) else $error("merge");
   extract_zero_a: assert property (issue_valid && req.op == OP_XTR_B |=>
      (res.dest_data & ~(64'hff << 8*(7-p_q.idst))) == 64'h0) else $error("extract rest");
   acc_pulse_a: assert property (res.acc_we |-> res_valid) else $error("acc write alone");
   acc_only_a: assert property (issue_valid && !(req.op inside {OP_SPLAT_FI, OP_SPLAT_I} && req.vrnt[3])
      |=> !res.acc_we) else $error("acc write");
   cover property (issue_valid && req.op == OP_SPLAT_I && req.vrnt[3]);
   cover property (issue_valid [*4]);
   cover property (issue_valid && req.op == DEST_SOURCE_PERMUTE_OP);
endmodule : vsp_unit_checker
bind vector_select_permute_unit vsp_unit_checker u_vsp_unit_checker (.sys_clk, .rst,
   .issue_valid, .req, .cond_reg, .rnd_mode, .res_valid, .res);

// >>> verification/core_writeback_model.sv
// accumulator side of the core that takes datapath results
`timescale 1ns/1ps
module core_writeback_model import vsp_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // result from datapath
   input wire logic res_valid,
   input wire result_t res,
   // held accumulator
   output logic [63:0] acc_q
);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_q <= 64'h0;
      end else if (res_valid && res.acc_we) begin
         acc_q <= res.acc_data;
      end
   end
endmodule : core_writeback_model

// >>> verification/vector_select_permute_unit_tb_top.sv
// self-checking bench for the select/permute datapath
`timescale 1ns/1ps
module vector_select_permute_unit_tb_top import vsp_pkg::*;;
   logic sys_clk, rst, issue_valid, res_valid;
   request_t req;
   logic [31:0] cond_reg, lf;
   rnd_mode_t rnd_mode;
   result_t res, ex;
   result_t q_exp[$];
   logic [63:0] acc_q, exp_acc = 64'h0;
   int n_errors = 0, total_checks = 0, cyc = 0;
   op_t ops[14] = '{OP_NONE, OP_SEL, OP_SELBIT, MASK_ZERO_INSERT_OP, MASK_ONE_INSERT_OP, OP_DLV_B, OP_MERGE, OP_PERM,
      DUAL_SOURCE_PERMUTE_OP, DEST_SOURCE_PERMUTE_OP, OP_PACK_HB, OP_SPLAT_I, OP_XTR_B, OP_INS_B};
   vector_select_permute_unit u_vector_select_permute_unit (.sys_clk, .rst, .issue_valid,
      .req, .cond_reg, .rnd_mode, .res_valid, .res);
   core_writeback_model u_core_writeback_model (.sys_clk, .rst, .res_valid, .res, .acc_q);
   // ******
   // helpers
   // ******
   function automatic logic [31:0] nxt(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   function automatic logic [7:0] sat8(logic [15:0] h);
      return ($signed(h) > 127) ? 8'h7f : ($signed(h) < -128) ? 8'h80 : h[7:0];
   endfunction : sat8
   function automatic result_t model(request_t r, logic [31:0] c);
      result_t y;
      logic [63:0] a, b, d, e;
      logic [127:0] s;
      logic [3:0] k;
      a = r.first_source_reg;
      b = r.second_source_reg;
      d = r.dest_reg;
      e = 64'(signed'(r.signed_small_immediate));
      y = '{dest_data: d, acc_we: 1'b0, acc_data: 64'h0};
      s = (r.op == DUAL_SOURCE_PERMUTE_OP) ? {a, b} : (r.op == DEST_SOURCE_PERMUTE_OP) ? {d, b} : {b, b};
      case (r.op)
         OP_SEL: y.dest_data = {c[31-4*r.condition_field_select] ? a[63:32] : b[63:32],
            c[30-4*r.condition_field_select] ? a[31:0] : b[31:0]};
         OP_SELBIT: y.dest_data = (d & a) | (~d & b);
         MASK_ZERO_INSERT_OP: y.dest_data = (~a & b) | (a & d);
         MASK_ONE_INSERT_OP: y.dest_data = (a & b) | (~a & d);
         OP_MERGE: y.dest_data = {r.vrnt[1] ? a[31:0] : a[63:32], r.vrnt[0] ? b[31:0] : b[63:32]};
         OP_DLV_B: for (int i = 0; i < 4; i++) begin
            y.dest_data[63-8*i -: 8] = a[63-8*(2*i+r.vrnt[1]) -: 8];
            y.dest_data[31-8*i -: 8] = b[63-8*(2*i+r.vrnt[0]) -: 8];
         end
         OP_PERM, DUAL_SOURCE_PERMUTE_OP, DEST_SOURCE_PERMUTE_OP: for (int i = 0; i < 8; i++) begin
            k = (r.op == DUAL_SOURCE_PERMUTE_OP) ? d[59-8*i -: 4] : a[59-8*i -: 4];
            if (r.op == OP_PERM) k[3] = 1'b0;
            y.dest_data[63-8*i -: 8] = s[127-8*k -: 8];
         end
         OP_PACK_HB: for (int i = 0; i < 4; i++) begin
            y.dest_data[63-8*i -: 8] = sat8(a[63-16*i -: 16]);
            y.dest_data[31-8*i -: 8] = sat8(b[63-16*i -: 16]);
         end
         OP_SPLAT_I: begin
            y.dest_data = (r.vrnt[1:0] == SZ_B) ? {8{e[7:0]}} : (r.vrnt[1:0] == SZ_H) ? {4{e[15:0]}} :
               (r.vrnt[1:0] == SZ_W) ? {2{e[31:0]}} : e;
            y.acc_we = r.vrnt[3];
            y.acc_data = y.dest_data;
         end
         OP_XTR_B, OP_INS_B: begin
            if (r.op == OP_XTR_B) y.dest_data = 64'h0;
            y.dest_data[63-8*r.idst -: 8] = a[63-8*r.isrc -: 8];
         end
         default: ;
      endcase
      return y;
   endfunction : model
   task automatic check(logic [63:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // ******
   // clock, monitor and stimulus
   // ******
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // the cycle ceiling is five times the expected run
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_errors++;
         results();
      end
      if (!rst && res_valid === 1'b1) begin
         ex = q_exp.pop_front();
         check(res.dest_data, ex.dest_data);
         check({63'h0, res.acc_we}, {63'h0, ex.acc_we});
         if (ex.acc_we) check(res.acc_data, ex.acc_data);
      end
   end
   initial begin
      request_t r;
      result_t m;
      logic [255:0] rv;
      rst = 1'b1;
      issue_valid = 1'b0;
      req = '0;
      cond_reg = 32'h0;
      rnd_mode = RND_NEAREST;
      lf = 32'h306e;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      // back to back at first, then with random gaps
      for (int n = 0; n < 600; n++) begin
         @(posedge sys_clk);
         for (int j = 0; j < 8; j++) begin
            lf = nxt(lf);
            rv = {rv[223:0], lf};
         end
         r = request_t'(rv[214:0]);
         r.op = ops[lf % 14];
         if (r.op == OP_SPLAT_I) r.vrnt[2] = 1'b0;
         if (r.op == OP_PACK_HB) r.vrnt = 4'h0;
         issue_valid <= (n < 100) || lf[20];
         req <= r;
         cond_reg <= rv[255:224];
         rnd_mode <= rnd_mode_t'(lf[9:8]);
         if ((n < 100) || lf[20]) begin
            m = model(r, rv[255:224]);
            q_exp.push_back(m);
            if (m.acc_we) exp_acc = m.acc_data;
         end
      end
      @(posedge sys_clk);
      issue_valid <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check(acc_q, exp_acc);
      check(64'(q_exp.size()), 64'h0);
      $display("random operation test done");
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      check(res.dest_data | {63'h0, res_valid}, 64'h0);
      $display("mid-run reset test done");
      results();
   end
endmodule : vector_select_permute_unit_tb_top
